// ---- hw/acaf_core.sv ----
// Add, add-with-carry and AND datapath with condition flags, APB controlled
`timescale 1ns/1ps
module acaf_core (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [acaf_pkg::ACAF_DW-1:0]  pwdata,
  output logic      [acaf_pkg::ACAF_DW-1:0]  prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic      [7:0]                    flags
);
  import acaf_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [ACAF_DW-1:0] size_mask(input logic [1:0] sz);
    if (sz == ACAF_SZ_BYTE) begin
      size_mask = 32'h000000FF;
    end else if (sz == ACAF_SZ_WORD) begin
      size_mask = 32'h0000FFFF;
    end else begin
      size_mask = 32'hFFFFFFFF;
    end
  endfunction : size_mask

  function automatic int msb_of(input logic [1:0] sz);
    if (sz == ACAF_SZ_BYTE) begin
      msb_of = 7;
    end else if (sz == ACAF_SZ_WORD) begin
      msb_of = 15;
    end else begin
      msb_of = 31;
    end
  endfunction : msb_of

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ACAF_IDLE, ACAF_FETCH, ACAF_EXEC} acaf_st_t;

  typedef struct packed {
    acaf_st_t           st;
    logic               ext_pend;
    logic               op_and;
    logic               op_adc;
    logic               dmem;
    logic [1:0]         sz;
    logic [3:0]         rs;
    logic [3:0]         rd;
    logic               rr;
    logic [ACAF_DW-1:0] memop;
    logic [ACAF_DW-1:0] result;
    logic [3:0]         regsel;
    logic [7:0]         flags;
    logic               bad_op;
    logic               rf_busy;
    logic               rvalid;
    logic [ACAF_DW-1:0] rdata;
  } acaf_state_t;

  acaf_state_t r;
  acaf_state_t next_r;

  logic               wr;
  logic               rd_acc;
  logic               rf_we;
  logic [3:0]         rf_waddr;
  logic [ACAF_DW-1:0] rf_wdata;
  logic [ACAF_DW-1:0] rf_a;
  logic [ACAF_DW-1:0] rf_b;
  logic [ACAF_DW-1:0] rd_mux;

  acaf_regfile u_rf (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (rf_we),
    .waddr   (rf_waddr),
    .wdata   (rf_wdata),
    .raddr_a (r.st == ACAF_IDLE ? r.regsel : r.rd),
    .raddr_b (r.rs),
    .rdata_a (rf_a),
    .rdata_b (rf_b)
  );

  assign wr     = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  // Writes complete at once when idle; a read waits for its captured word,
  // which costs one wait state but keeps prdata on a flip-flop.
  assign pready  = (r.st == ACAF_IDLE) && (pwrite || r.rvalid);
  assign pslverr = 1'b0;
  assign prdata  = r.rdata;
  assign flags   = r.flags;

  // ----------------------------------------------------------------
  // Execute and register writes
  // ----------------------------------------------------------------
  logic [ACAF_DW-1:0] dst_v;
  logic [ACAF_DW-1:0] src_v;
  logic [ACAF_DW-1:0] mask;
  logic [ACAF_DW:0]   sum;
  logic [ACAF_DW-1:0] res;
  logic               cout;
  logic               ovf;
  logic               msb_d;
  logic               msb_s;
  logic               msb_r;
  int                 m;

  always_comb begin
    next_r   = r;
    rf_we    = 1'b0;
    rf_waddr = r.rd;
    rf_wdata = '0;
    next_r.rf_busy = 1'b0;
    next_r.rvalid  = 1'b0;
    // Capture only once the read port has settled on the selected register,
    // so a read never returns a word from before the last write-back
    if (rd_acc && r.st == ACAF_IDLE && !r.rvalid && !r.rf_busy) begin
      next_r.rdata  = rd_mux;
      next_r.rvalid = 1'b1;
    end else if (rd_acc) begin
      next_r.rdata  = '0;
    end
    // register destinations use the full width
    mask  = r.dmem ? size_mask(r.sz) : 32'hFFFFFFFF;
    m     = r.dmem ? msb_of(r.sz) : ACAF_DW - 1;
    dst_v = (r.dmem ? r.memop : rf_a) & mask;
    src_v = rf_b & mask;
    sum   = {1'b0, dst_v} + {1'b0, src_v}
            + {{ACAF_DW{1'b0}}, (r.op_adc & r.flags[ACAF_F_C])};
    res   = r.op_and ? (dst_v & src_v) : (sum[ACAF_DW-1:0] & mask);
    cout  = sum[m + 1];
    msb_d = dst_v[m];
    msb_s = src_v[m];
    msb_r = res[m];
    ovf   = (msb_d == msb_s) && (msb_r != msb_d);

    if (r.st == ACAF_EXEC) begin
      next_r.st      = ACAF_IDLE;
      next_r.result  = res;
      next_r.rf_busy = 1'b1;
      if (!r.dmem) begin
        rf_we    = 1'b1;
        rf_wdata = res;
      end
      if (!r.op_and) begin
        next_r.flags[ACAF_F_C] = cout;
        next_r.flags[ACAF_F_V] = ovf;
      end else begin
        next_r.flags[ACAF_F_V] = 1'b0;
      end
      if (r.op_adc) begin
        next_r.flags[ACAF_F_Z] = r.flags[ACAF_F_Z] && (res == '0);
      end else begin
        next_r.flags[ACAF_F_Z] = (res == '0);
      end
      next_r.flags[ACAF_F_S] = msb_r;
      next_r.flags[ACAF_F_B] = (dst_v == '0) || (src_v == '0);
      // Bits 2, 1 and 0 are carried over untouched by next_r = r.
    end else if (r.st == ACAF_FETCH) begin
      next_r.st = ACAF_EXEC; // Operands appear on the registered read ports
    end else begin
      if (wr && paddr == ACAF_A_CTRL && pwdata[ACAF_C_GO]) begin
        next_r.op_and   = pwdata[ACAF_C_OP];
        next_r.op_adc   = !pwdata[ACAF_C_OP] && r.ext_pend;
        next_r.dmem     = pwdata[ACAF_C_DMEM];
        next_r.sz       = pwdata[ACAF_C_SZ +: 2];
        next_r.ext_pend = 1'b0;
        next_r.st       = ACAF_FETCH;
      end else if (wr && paddr == ACAF_A_INSTR) begin
        if (pwdata[15:0] == ACAF_EXT_PREFIX) begin
          next_r.ext_pend = 1'b1;
          next_r.bad_op   = 1'b0;
        end else if (pwdata[15:8] == ACAF_RR_ADD_CODE
                     || pwdata[15:8] == ACAF_RR_AND_CODE) begin
          next_r.rs       = pwdata[7:4];
          next_r.rd       = pwdata[3:0];
          next_r.op_and   = (pwdata[15:8] == ACAF_RR_AND_CODE);
          next_r.op_adc   = (pwdata[15:8] == ACAF_RR_ADD_CODE) && r.ext_pend;
          next_r.dmem     = 1'b0;
          next_r.ext_pend = 1'b0;
          next_r.bad_op   = 1'b0;
          next_r.st       = ACAF_FETCH;
        end else begin
          next_r.bad_op   = 1'b1;
          next_r.ext_pend = 1'b0;
        end
      end else if (wr && paddr == ACAF_A_MEMOP) begin
        next_r.memop = pwdata;
        next_r.rs    = pwdata[ACAF_DW-1 -: 4];
      end else if (wr && paddr == ACAF_A_FLAGS) begin
        next_r.flags = pwdata[7:0];
      end else if (wr && paddr == ACAF_A_REGSEL) begin
        next_r.regsel  = pwdata[3:0];
        next_r.rf_busy = 1'b1;
      end else if (wr && paddr == ACAF_A_REGDAT) begin
        next_r.rf_busy = 1'b1;
        rf_we    = 1'b1;
        rf_waddr = r.regsel;
        rf_wdata = pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r        <= '0;
      r.st     <= ACAF_IDLE;
      r.flags  <= ACAF_FLAGS_RST;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    if (paddr == ACAF_A_MEMOP) begin
      rd_mux = r.memop;
    end else if (paddr == ACAF_A_FLAGS) begin
      rd_mux = {24'h000000, r.flags};
    end else if (paddr == ACAF_A_RESULT) begin
      rd_mux = r.result;
    end else if (paddr == ACAF_A_REGSEL) begin
      rd_mux = {28'h0000000, r.regsel};
    end else if (paddr == ACAF_A_REGDAT) begin
      rd_mux = rf_a;
    end else if (paddr == ACAF_A_STATUS) begin
      rd_mux = {29'h0, r.bad_op, r.ext_pend, (r.st != ACAF_IDLE)};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_enable_bits_kept: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC |=> flags[1:0] == $past(flags[1:0]))
    else $error("interrupt enable bits changed by operation");
  a_and_clears_v: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC && r.op_and |=> !flags[ACAF_F_V]
      && flags[ACAF_F_C] == $past(flags[ACAF_F_C]))
    else $error("and changed carry or kept overflow");
  a_adc_zero_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC && r.op_adc && !r.flags[ACAF_F_Z] |=> !flags[ACAF_F_Z])
    else $error("carry add set zero from clear");
  a_zero_matches: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC && !r.op_adc |=> flags[ACAF_F_Z] == (r.result == '0))
    else $error("zero flag mismatch");
  a_sign_matches: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC && !r.dmem |=> flags[ACAF_F_S] == r.result[ACAF_DW-1])
    else $error("sign flag mismatch");
  a_prefix_to_adc: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_IDLE && r.ext_pend && wr && paddr == ACAF_A_INSTR
      && pwdata[15:8] == ACAF_RR_ADD_CODE |=> r.op_adc ##2 r.st == ACAF_IDLE)
    else $error("prefix did not select carry add");
  a_blank_flag: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC |=> flags[ACAF_F_B] == $past((dst_v == '0) || (src_v == '0)))
    else $error("blank flag mismatch");
  // Of the checks below, a_rr_writeback and a_overflow_add recompute from the operand ports; a_carry_out uses the datapath net sum
  a_rr_writeback: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC && !r.dmem |-> rf_we && rf_waddr == r.rd
      && rf_wdata == (r.op_and ? (rf_a & rf_b)
                      : rf_a + rf_b + ACAF_DW'(r.op_adc & r.flags[ACAF_F_C])))
    else $error("register result not written");
  a_overflow_add: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC && !r.op_and && !r.dmem
      |=> flags[ACAF_F_V] == ($past(rf_a[ACAF_DW-1]) == $past(rf_b[ACAF_DW-1])
          && r.result[ACAF_DW-1] != $past(rf_a[ACAF_DW-1])))
    else $error("overflow flag mismatch");
  a_adc_zero_kept: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC && r.op_adc && r.flags[ACAF_F_Z] |=> flags[ACAF_F_Z] == (r.result == '0))
    else $error("carry add zero flag mismatch");
  a_byte_masked: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC && r.dmem && r.sz == ACAF_SZ_BYTE |=> r.result[ACAF_DW-1:8] == '0)
    else $error("byte result wider than its size");
  a_word_masked: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC && r.dmem && r.sz == ACAF_SZ_WORD |=> r.result[ACAF_DW-1:16] == '0)
    else $error("word result wider than its size");
  a_mem_src_kept: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC && r.dmem |-> !rf_we)
    else $error("memory operation wrote a register");
  a_carry_out: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ACAF_EXEC && !r.op_and && !r.dmem
      |=> flags[ACAF_F_C] == $past(sum[ACAF_DW]))
    else $error("carry flag mismatch");
endmodule : acaf_core

// ---- hw/acaf_pkg.sv ----
// Package: constants, register map and types for the add/carry/AND flag datapath
package acaf_pkg;
  // ----------------------------------------------------------------
  // Widths and encodings
  // ----------------------------------------------------------------
  localparam int          ACAF_DW          = 32;
  localparam logic [15:0] ACAF_EXT_PREFIX  = 16'h0007;
  localparam logic [7:0]  ACAF_RR_ADD_CODE = 8'hA0;
  localparam logic [7:0]  ACAF_RR_AND_CODE = 8'hA2;
  localparam int          ACAF_NREG        = 16;
  // ----------------------------------------------------------------
  // Flag byte layout
  // ----------------------------------------------------------------
  localparam int ACAF_F_C    = 7;
  localparam int ACAF_F_Z    = 6;
  localparam int ACAF_F_S    = 5;
  localparam int ACAF_F_V    = 4;
  localparam int ACAF_F_B    = 3;
  localparam int ACAF_F_CIE  = 1;
  localparam int ACAF_F_MIE  = 0;
  localparam logic [7:0] ACAF_FLAGS_RST = 8'h00;
  // ----------------------------------------------------------------
  // APB register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ACAF_A_CTRL   = 8'h00;
  localparam logic [7:0] ACAF_A_INSTR  = 8'h04;
  localparam logic [7:0] ACAF_A_MEMOP  = 8'h08;
  localparam logic [7:0] ACAF_A_FLAGS  = 8'h0C;
  localparam logic [7:0] ACAF_A_RESULT = 8'h10;
  localparam logic [7:0] ACAF_A_REGSEL = 8'h14;
  localparam logic [7:0] ACAF_A_REGDAT = 8'h18;
  localparam logic [7:0] ACAF_A_STATUS = 8'h1C;
  // CTRL fields
  localparam int ACAF_C_OP   = 0;  // 0 add, 1 and
  localparam int ACAF_C_DMEM = 2;  // destination in memory
  localparam int ACAF_C_SZ   = 3;  // 2 bits size
  localparam int ACAF_C_GO   = 8;  // write 1 executes
  localparam logic [1:0] ACAF_SZ_BYTE = 2'h0;
  localparam logic [1:0] ACAF_SZ_WORD = 2'h1;
  localparam logic [1:0] ACAF_SZ_QUAD = 2'h2;

  typedef enum logic [1:0] {ACAF_OP_ADD, ACAF_OP_ADC, ACAF_OP_AND, ACAF_OP_NONE} acaf_op_t;
endpackage : acaf_pkg

// ---- hw/acaf_regfile.sv ----
// Sixteen-entry register file with registered read data
`timescale 1ns/1ps
module acaf_regfile (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          we,
  input  wire logic [3:0]                    waddr,
  input  wire logic [acaf_pkg::ACAF_DW-1:0]  wdata,
  input  wire logic [3:0]                    raddr_a,
  input  wire logic [3:0]                    raddr_b,
  output logic      [acaf_pkg::ACAF_DW-1:0]  rdata_a,
  output logic      [acaf_pkg::ACAF_DW-1:0]  rdata_b
);
  import acaf_pkg::*;

  logic [ACAF_DW-1:0] mem [ACAF_NREG];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ACAF_NREG; i++) begin
        mem[i] <= '0;
      end
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end
endmodule : acaf_regfile

// ---- sim/add_carry_and_alu_flags_test.sv ----
// Self-checking testbench for the add, add-with-carry and AND flag datapath
`timescale 1ns/1ps
module add_carry_and_alu_flags_test;
  import acaf_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [ACAF_DW-1:0] pwdata;
  logic [ACAF_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic [7:0]        flags;
  int                err_count;
  int                n_compared;

  acaf_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flags(flags));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      err_count++;
      end_sim();
    end
    q = prdata;
    chk({31'h0, pslverr}, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic setr(input logic [3:0] r, input logic [31:0] v);
    wr(ACAF_A_REGSEL, {28'h0, r});
    wr(ACAF_A_REGDAT, v);
  endtask : setr

  // Register-destination op: flags preset, optional prefix, one encoded word
  task automatic rr(input logic pre, input logic [7:0] code, input logic [3:0] s,
                    input logic [3:0] d, input logic [31:0] sv, input logic [31:0] dv,
                    input logic [31:0] ev, input logic [7:0] f0, input logic [7:0] fe);
    setr(s, sv);
    setr(d, dv);
    wr(ACAF_A_FLAGS, {24'h0, f0});
    if (pre) wr(ACAF_A_INSTR, {16'h0, ACAF_EXT_PREFIX});
    wr(ACAF_A_INSTR, {16'h0, code, s, d});
    wr(ACAF_A_REGSEL, {28'h0, d});
    rd(ACAF_A_REGDAT, ev);
    wr(ACAF_A_REGSEL, {28'h0, s});
    rd(ACAF_A_REGDAT, sv);
    chk({24'h0, flags}, {24'h0, fe});
  endtask : rr

  // Memory-destination op; the result comes back masked to the access size
  task automatic mo(input logic pre, input logic [31:0] ctrl, input logic [31:0] mem,
                    input logic [31:0] sv, input logic [7:0] f0, input logic [31:0] ev,
                    input logic [7:0] fe);
    setr(mem[31:28], sv);
    wr(ACAF_A_FLAGS, {24'h0, f0});
    if (pre) wr(ACAF_A_INSTR, {16'h0, ACAF_EXT_PREFIX});
    wr(ACAF_A_MEMOP, mem);
    wr(ACAF_A_CTRL, ctrl);
    rd(ACAF_A_RESULT, ev);
    chk({24'h0, flags}, {24'h0, fe});
  endtask : mo

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({24'h0, flags}, {24'h0, ACAF_FLAGS_RST});
    rd(ACAF_A_RESULT, 32'h0);
    rd(8'h20, 32'h0);
    wr(ACAF_A_INSTR, 32'h0000_FFFF);
    rd(ACAF_A_STATUS, 32'h4);
    $display("reset and bus test done");
  endtask : t_reset

  task automatic t_add();
    rr(0, 8'hA0, 4'hB, 4'h3, 32'h20, 32'h16, 32'h36, 8'h00, 8'h00);
    rr(0, 8'hA0, 4'h2, 4'h1, 32'h1, 32'hFFFF_FFFF, 32'h0, 8'h00, 8'hC0);
    rr(0, 8'hA0, 4'h5, 4'h4, 32'h1, 32'h7FFF_FFFF, 32'h8000_0000, 8'h03, 8'h33);
    rr(0, 8'hA0, 4'h7, 4'h6, 32'h5, 32'h0, 32'h5, 8'h00, 8'h08);
    rr(0, 8'hA0, 4'h9, 4'h8, 32'h1, 32'hFF, 32'h100, 8'h00, 8'h00);
    $display("add test done");
  endtask : t_add

  task automatic t_adc();
    rr(1, 8'hA0, 4'hB, 4'h3, 32'h20, 32'h16, 32'h37, 8'h80, 8'h00);
    rr(1, 8'hA0, 4'h7, 4'h6, 32'h1, 32'hFFFF_FFFE, 32'h0, 8'h80, 8'h80);
    rr(1, 8'hA0, 4'h7, 4'h6, 32'h1, 32'hFFFF_FFFE, 32'h0, 8'hC0, 8'hC0);
    rr(1, 8'hA0, 4'hB, 4'h3, 32'h0, 32'h16, 32'h17, 8'hC1, 8'h09);
    rr(0, 8'hA0, 4'hB, 4'h3, 32'h20, 32'h16, 32'h36, 8'h80, 8'h00);
    $display("carry add test done");
  endtask : t_adc

  task automatic t_and();
    rr(0, ACAF_RR_AND_CODE, 4'hE, 4'h1, 32'h8D, 32'h38, 32'h08, 8'h93, 8'h83);
    rr(0, ACAF_RR_AND_CODE, 4'h3, 4'h2, 32'h5, 32'h0, 32'h0, 8'h10, 8'h48);
    rr(0, ACAF_RR_AND_CODE, 4'h1, 4'h0, 32'h8000_0000, 32'hFFFF_FFFF, 32'h8000_0000,
       8'h00, 8'h20);
    $display("and test done");
  endtask : t_and

  task automatic t_mem();
    mo(0, 32'h104, 32'h5000_00FF, 32'h1, 8'h00, 32'h0, 8'hC0);
    mo(0, 32'h10C, 32'h6000_FFFF, 32'h2, 8'h00, 32'h1, 8'h80);
    mo(0, 32'h104, 32'h5000_007F, 32'h1, 8'h00, 32'h80, 8'h30);
    mo(1, 32'h104, 32'h5000_0010, 32'h1, 8'h80, 32'h12, 8'h00);
    mo(0, 32'h105, 32'h5000_0080, 32'h181, 8'h80, 32'h80, 8'hA0);
    mo(0, 32'h114, 32'h2000_0000, 32'hE000_0000, 8'h00, 32'h0, 8'hC0);
    $display("memory destination test done");
  endtask : t_mem

  // ----------------------------------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    err_count  = 0;
    n_compared = 0;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_add();
    t_adc();
    t_and();
    t_mem();
    end_sim();
  end
endmodule : add_carry_and_alu_flags_test
